// ===== gps_port.sv
/*
  One general-purpose pin port: direction and output latch registers,
  readback synchroniser, sleep clamp and alternate-function overrides,
  reached over APB.
  Assumes pad inputs already resolved to a clean level by the pad ring and
  override signals synchronous to pclk.
*/
// Chosen here: the APB interface to the registers and the address map.

// Summary of operation
// - Pin level readable regardless of direction
// - Latch on falling edge, register on rising
// - External edge visible after half to 1.5 periods
// - Software-driven value readable one clock later
// - Sleep clamp forces input to ground
// - External interrupt enable suppresses the clamp
// - Clamp edge may set interrupt flag on wake
// - Pull-up follows override or dir/latch/disable 010 while the driver is off
// - Driver enable follows override or direction bit
// - Driven level is override value or latch
// - Toggle override inverts the output latch bit
// - Input enable follows override regardless of sleep
// - Alternate input tapped before the synchroniser
// - Strobes per port, clamp/disable shared, overrides per pin
// - Direction one is output; latch requests pull-up
// - Writing one to readback toggles the latch
// - Global pull-up disable kills every pull-up not under override
// - Reset gives tri-state inputs, pull-up off
module gps_port #(
  parameter int WIDTH = gps_pkg::GPS_DEF_WIDTH
) (
  // APB register bus
  input  wire  logic                          pclk,
  input  wire  logic                          presetn,
  input  wire  logic                          psel,
  input  wire  logic                          penable,
  input  wire  logic                          pwrite,
  input  wire  logic [11:0]                   paddr,
  input  wire  logic [31:0]                   pwdata,
  output logic                                pready,
  output logic [31:0]                         prdata,
  output logic                                pslverr,
  // Sleep controller, shared by all pins, and per-pin interrupt enables
  input  wire  logic                          sleep_clamp,
  input  wire  logic [WIDTH-1:0]              ext_int_enable,
  // Alternate-function overrides, one bundle per pin
  input  wire  gps_pkg::gps_override_s [WIDTH-1:0] override_in,
  // Pad side and the tap for alternate functions
  input  wire  logic [WIDTH-1:0]              pad_in,
  output logic [WIDTH-1:0]                    pad_out,
  output logic [WIDTH-1:0]                    pad_oe,
  output logic [WIDTH-1:0]                    pad_pullup,
  output logic [WIDTH-1:0]                    alt_function_digital_in,
  output logic                                global_pullup_disable
);

  // ==========================================================================
  // APB slave: one wait state, answer registered
  // ==========================================================================
  // Registering the answer costs a wait state but keeps pready and prdata
  // free of glitches from the address decode
  logic              pready_reg;
  logic              pready_next;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  logic              wr_fire;
  logic              rd_fire;
  logic              hit_readback;
  logic              hit_direction;
  logic              hit_latch;
  logic              hit_control;
  logic              mapped;

  // Strobes below are common to every pin slice of this port
  // Only the four aligned words decode; anything else answers pslverr
  always_comb
  begin
    hit_readback  = 1'b0;
    hit_direction = 1'b0;
    hit_latch     = 1'b0;
    hit_control   = 1'b0;
    case (paddr)
      gps_pkg::GPS_OFS_READBACK:
        hit_readback = 1'b1;
      gps_pkg::GPS_OFS_DIRECTION:
        hit_direction = 1'b1;
      gps_pkg::GPS_OFS_OUT_LATCH:
        hit_latch = 1'b1;
      gps_pkg::GPS_OFS_CONTROL:
        hit_control = 1'b1;
      default:
        hit_control = 1'b0;
    endcase
    mapped  = hit_readback | hit_direction | hit_latch | hit_control;
    // A write lands at the edge that also shows pready to the master
    wr_fire = psel & penable & pready_reg & pwrite & mapped;
    // Read data is captured one edge early so that it stands with pready
    rd_fire = psel & penable & ~pready_reg & ~pwrite;
  end

  logic [WIDTH-1:0]  direction_reg;
  logic [WIDTH-1:0]  direction_next;
  logic [WIDTH-1:0]  latch_reg;
  logic [WIDTH-1:0]  latch_next;
  logic              pud_reg;
  logic              pud_next;
  logic [WIDTH-1:0]  readback_reg;
  logic [WIDTH-1:0]  toggle_ov;

  always_comb
  begin
    pready_next  = psel & penable & ~pready_reg;
    pslverr_next = psel & penable & ~pready_reg & ~mapped;
    prdata_next  = prdata_reg;
    if (rd_fire)
    begin
      // Upper bits, and every unmapped offset, read as zero
      prdata_next = 32'h0000_0000;
      case (paddr)
        gps_pkg::GPS_OFS_READBACK:
          prdata_next[WIDTH-1:0] = readback_reg;
        gps_pkg::GPS_OFS_DIRECTION:
          prdata_next[WIDTH-1:0] = direction_reg;
        gps_pkg::GPS_OFS_OUT_LATCH:
          prdata_next[WIDTH-1:0] = latch_reg;
        gps_pkg::GPS_OFS_CONTROL:
          prdata_next[gps_pkg::GPS_CTRL_PUD_BIT] = pud_reg;
        default:
          prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= pready_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================================
  // Write strobes
  // ==========================================================================
  // One strobe per register, shared by all pins of the port
  logic              wr_readback;
  logic              wr_direction;
  logic              wr_latch;
  logic              wr_control;

  always_comb
  begin
    wr_readback  = wr_fire & hit_readback;
    wr_direction = wr_fire & hit_direction;
    wr_latch     = wr_fire & hit_latch;
    wr_control   = wr_fire & hit_control;
  end

  // ==========================================================================
  // Port registers
  // ==========================================================================
  always_comb
  begin
    direction_next = direction_reg;
    pud_next       = pud_reg;
    latch_next     = latch_reg;
    if (wr_direction)
      direction_next = pwdata[WIDTH-1:0];
    if (wr_latch)
      latch_next = pwdata[WIDTH-1:0];
    if (wr_readback)
      latch_next = latch_reg ^ pwdata[WIDTH-1:0];
    // A toggle strobe beside a write flips the written value; neither is lost
    latch_next = latch_next ^ toggle_ov;
    if (wr_control)
      pud_next = pwdata[gps_pkg::GPS_CTRL_PUD_BIT];
  end

  // Reset needs no clock: every pin goes input, undriven, no pull-up
  // Control clears too, so pull-ups obey the latch bits from the start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      direction_reg <= gps_pkg::GPS_RST_DIRECTION[WIDTH-1:0];
      latch_reg     <= gps_pkg::GPS_RST_OUT_LATCH[WIDTH-1:0];
      pud_reg       <= gps_pkg::GPS_RST_PUD;
    end
    else
    begin
      direction_reg <= direction_next;
      latch_reg     <= latch_next;
      pud_reg       <= pud_next;
    end
  end

  // ==========================================================================
  // Pin slices
  // ==========================================================================
  logic [WIDTH-1:0]  input_gated;
  logic [WIDTH-1:0]  sync_latch_reg;
  logic [WIDTH-1:0]  readback_next;
  gps_pkg::gps_pad_drive_s [WIDTH-1:0] drive;

  // Identical slice per pin, each with its own overrides
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_pin
    logic input_enable;
    logic pull_normal;

    // Input side: enable, clamp and the tap for alternate functions
    always_comb
    begin
      // Interrupt-enabled pins keep their input alive in sleep
      if (override_in[i].input_enable_override_enable)
        input_enable = override_in[i].input_enable_override_value;
      else
        input_enable = ~(sleep_clamp & ~ext_int_enable[i]);
      // Clamp to ground; a high pin then rises again on wake
      input_gated[i] = input_enable & pad_in[i];
    end

    // Output side: toggle strobe, pull-up, driver enable and level
    always_comb
    begin
      toggle_ov[i] = override_in[i].toggle_override_enable;
      pull_normal = ({direction_reg[i], latch_reg[i], pud_reg} == 3'b010);
      if (override_in[i].pullup_override_enable)
        drive[i].pullup_enable = override_in[i].pullup_override_value;
      else
        drive[i].pullup_enable = pull_normal;
      if (override_in[i].direction_override_enable)
        drive[i].out_enable = override_in[i].direction_override_value;
      else
        drive[i].out_enable = direction_reg[i];
      // The value override only matters while the driver is on
      if (override_in[i].value_override_enable)
        drive[i].out_value = override_in[i].value_override_value;
      else
        drive[i].out_value = latch_reg[i];
      // A pull-up fighting its own driver only wastes current
      pad_out[i]    = drive[i].out_value & drive[i].out_enable;
      pad_oe[i]     = drive[i].out_enable;
      pad_pullup[i] = drive[i].pullup_enable & ~drive[i].out_enable;
    end
  end

  // ==========================================================================
  // Alternate-function tap
  // ==========================================================================
  // Alternate functions see the raw gated level; they sync it themselves
  always_comb
  begin
    alt_function_digital_in = input_gated;
    readback_next           = sync_latch_reg;
  end

  // ==========================================================================
  // Readback synchroniser
  // ==========================================================================
  // The falling-edge stage stands in for a latch open while the clock is
  // high; its value is the one the latch would hold when it closes.
  // Only readback_reg reads this stage, so a value caught near the edge
  // gets half a clock to settle before anything uses it.
  always_ff @(negedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_latch_reg <= '0;
    else
      sync_latch_reg <= input_gated;
  end

  // A write that drives the pin lands here one full clock later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      readback_reg <= '0;
    else
      readback_reg <= readback_next;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Pad drive stays combinational so override and register changes reach
  // the pin in the same cycle; registering it would add a clock of skew.
  always_comb
  begin
    pready                = pready_reg;
    prdata                = prdata_reg;
    pslverr               = pslverr_reg;
    global_pullup_disable = pud_reg;
  end

endmodule : gps_port

// ===== gps_pkg.sv
/*
  Package for the general-purpose pin port: register offsets, reset values,
  field positions and the per-pin alternate-function override bundle.
  Assumes a 32-bit APB register bus and a port no wider than 32 pins.
*/
package gps_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [11:0] GPS_OFS_READBACK  = 12'h000;
  localparam logic [11:0] GPS_OFS_DIRECTION = 12'h004;
  localparam logic [11:0] GPS_OFS_OUT_LATCH = 12'h008;
  localparam logic [11:0] GPS_OFS_CONTROL   = 12'h00c;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam int          GPS_CTRL_PUD_BIT  = 0;
  localparam logic [31:0] GPS_RST_DIRECTION = 32'h0000_0000;
  localparam logic [31:0] GPS_RST_OUT_LATCH = 32'h0000_0000;
  localparam logic        GPS_RST_PUD       = 1'b0;
  localparam int          GPS_DEF_WIDTH     = 8;

  // ==========================================================================
  // Override bundle driven by an alternate-function module, one per pin
  // ==========================================================================
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic value_override_enable;
    logic value_override_value;
    logic toggle_override_enable;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } gps_override_s;

  // Drive to one pad
  typedef struct packed {
    logic out_value;
    logic out_enable;
    logic pullup_enable;
  } gps_pad_drive_s;

endpackage : gps_pkg

// ===== gps_port_asserts.sv
/*
  Checker for gps_port: overrides, clamp, pull-up and APB answer of pin 0.
  Assumes a bind to gps_port; the other pins are left to the bench.
*/
module gps_port_asserts #(
  parameter int WIDTH = 8
) (
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pready,
  input wire logic                             sleep_clamp,
  input wire logic [WIDTH-1:0]                 ext_int_enable,
  input wire gps_pkg::gps_override_s [WIDTH-1:0] override_in,
  input wire logic [WIDTH-1:0]                 pad_in,
  input wire logic [WIDTH-1:0]                 pad_out,
  input wire logic [WIDTH-1:0]                 pad_oe,
  input wire logic [WIDTH-1:0]                 pad_pullup,
  input wire logic [WIDTH-1:0]                 alt_function_digital_in,
  input wire logic                             global_pullup_disable
);
  // ==========================================================================
  // Pin 0 only, to keep the checker small
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  gps_pkg::gps_override_s o;
  assign o = override_in[0];

  a_dir_override:
    assert property (o.direction_override_enable |-> pad_oe[0] == o.direction_override_value)
    else $error("driver enable ignores override");
  a_val_override:
    assert property (pad_oe[0] && o.value_override_enable |-> pad_out[0] == o.value_override_value)
    else $error("driven level ignores override");
  a_pu_override:
    assert property (o.pullup_override_enable && !pad_oe[0] |-> pad_pullup[0] == o.pullup_override_value)
    else $error("pull-up ignores override");
  a_pud_off:
    assert property (global_pullup_disable && !o.pullup_override_enable |-> !pad_pullup[0])
    else $error("pull-up on while disabled");
  a_clamp_ground:
    assert property (sleep_clamp && !ext_int_enable[0] && !o.input_enable_override_enable
                     |-> !alt_function_digital_in[0])
    else $error("clamp not applied");
  a_int_unclamp:
    assert property (!o.input_enable_override_enable && (!sleep_clamp || ext_int_enable[0])
                     |-> alt_function_digital_in[0] == pad_in[0])
    else $error("input not passed");
  a_ie_override:
    assert property (o.input_enable_override_enable
                     |-> alt_function_digital_in[0] == (o.input_enable_override_value & pad_in[0]))
    else $error("input enable ignores override");
  a_ready_one:
    assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
    else $error("bus answer out of time");

  cover property (sleep_clamp && ext_int_enable[0]);
  cover property (o.direction_override_enable && o.value_override_enable);
  cover property (global_pullup_disable);
endmodule : gps_port_asserts

// ===== gps_pad_model.sv
/*
  Pad ring model: strong driver wins, then an outside source, then pull-up.
  Assumes an undriven pad with no pull-up reads opposite to ext_level.
*/
module gps_pad_model #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] pad_out,
  input  wire logic [WIDTH-1:0] pad_oe,
  input  wire logic [WIDTH-1:0] pad_pullup,
  input  wire logic [WIDTH-1:0] ext_en,
  input  wire logic [WIDTH-1:0] ext_level,
  output logic      [WIDTH-1:0] pad_in
);
  // ==========================================================================
  // Resolution; a floating pad never shows a helpful value
  // ==========================================================================
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_level[i]
                : pad_pullup[i] ? 1'b1 : ~ext_level[i];
  end
endmodule : gps_pad_model

// ===== tb.sv
/*
  Testbench for gps_port over APB with a pad model.
  Assumes answers well within the watchdog span and pads resolved by
  gps_pad_model.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 8;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, gpd, err, sleep_clamp = 1'b0;
  logic [31:0] prdata, rd;
  logic [W-1:0] ext_int_enable = 8'h00, ext_en = 8'h30, ext_level = 8'h00;
  logic [W-1:0] pad_in, pad_out, pad_oe, pad_pullup, alt;
  gps_pkg::gps_override_s [W-1:0] ov = '0;
  int errors = 0, comparisons = 0;

  always #20 pclk = ~pclk;

  gps_port #(.WIDTH(W)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sleep_clamp(sleep_clamp),
    .ext_int_enable(ext_int_enable), .override_in(ov), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .alt_function_digital_in(alt), .global_pullup_disable(gpd));
  gps_pad_model #(.WIDTH(W)) i_pad (.pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_level(ext_level), .pad_in(pad_in));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    // Setup after an edge; hold until pready is seen high at a rising edge
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic finish_test;
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (3000) @(posedge pclk);
    errors++;
    finish_test();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk(pad_oe | pad_pullup, 0);
    apb(1'b0, 12'h010, 0);
    chk({rd[30:0], err}, 1);
    apb(1'b1, gps_pkg::GPS_OFS_OUT_LATCH, 32'h0000_00c3);
    apb(1'b1, gps_pkg::GPS_OFS_DIRECTION, 32'h0000_000f);
    apb(1'b0, gps_pkg::GPS_OFS_READBACK, 0);
    chk(rd, 32'h0000_00c3);
    chk({pad_oe, pad_out, pad_pullup}, 24'h0f_03c0);
    apb(1'b1, gps_pkg::GPS_OFS_CONTROL, 1);
    @(negedge pclk);
    chk({gpd, pad_pullup}, 9'h100);
    apb(1'b1, gps_pkg::GPS_OFS_CONTROL, 0);
    apb(1'b1, gps_pkg::GPS_OFS_READBACK, 32'h0000_0081);
    @(posedge pclk);
    ov[1].toggle_override_enable <= 1'b1;
    @(posedge pclk);
    ov[1].toggle_override_enable <= 1'b0;
    apb(1'b0, gps_pkg::GPS_OFS_OUT_LATCH, 0);
    chk(rd, 32'h0000_0040);
    @(posedge pclk);
    ext_level <= 8'h10;
    @(negedge pclk);
    chk(alt[4], 1);
    apb(1'b0, gps_pkg::GPS_OFS_READBACK, 0);
    chk(rd, 32'h0000_00d0);
    @(posedge pclk);
    sleep_clamp <= 1'b1;
    ext_level <= 8'h30;
    @(negedge pclk);
    chk(alt, 0);
    apb(1'b0, gps_pkg::GPS_OFS_READBACK, 0);
    chk(rd, 0);
    @(posedge pclk);
    ext_int_enable <= 8'h11;
    ov[5].input_enable_override_enable <= 1'b1;
    ov[5].input_enable_override_value <= 1'b1;
    @(negedge pclk);
    chk(alt, 8'h30);
    @(posedge pclk);
    ov[4].input_enable_override_enable <= 1'b1;
    ov[0] <= 9'h003;
    @(negedge pclk);
    chk(alt, 8'h20);
    @(posedge pclk);
    sleep_clamp <= 1'b0;
    ov[W-1:1] <= '0;
    ov[0] <= 9'h1c0;
    @(negedge pclk);
    chk({pad_oe, pad_pullup}, 16'h0e41);
    @(posedge pclk);
    ov[0] <= 9'h078;
    @(negedge pclk);
    chk({pad_oe, pad_out}, 16'h0f01);
    finish_test();
  end
endmodule : tb

bind gps_port gps_port_asserts #(.WIDTH(WIDTH)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .sleep_clamp(sleep_clamp),
  .ext_int_enable(ext_int_enable), .override_in(override_in), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
  .alt_function_digital_in(alt_function_digital_in),
  .global_pullup_disable(global_pullup_disable));
